// [rtl/ssri_top.sv]
/*
 * System control soft reset and interrupt block with an AXI4-Lite slave.
 * Assumes one clock, a synchronous reset and asynchronous event pins.
 */
// What this block does
// - Writes to peripheral reset bits are gated by the peripheral capability mask.
// - Writes to GPIO port reset bits are gated by the GPIO capability mask.
// - Peripheral reset holds comparator 1 and 0 bits at 25, 24, cleared.
// - Peripheral reset holds timer 1 and 0 bits at 17, 16, cleared.
// - Peripheral reset holds serial bit 4 and UART bit 0, cleared.
// - GPIO reset holds port C, B, A bits at 2, 1, 0, cleared.
// - Reserved bits read as zero, except BOR control bits 14 to 2 and bit 0, which reset to one; software must not change them.
// - Raw status is read only, hardware driven, zero after reset.
// - Raw bit 6 sets when the PLL lock timer fires.
// - Raw bit 5 sets when the regulator current limit asserts.
// - Raw bit 4 sets on a boot oscillator fault.
// - Raw bit 3 sets on a main oscillator fault.
// - Raw bit 2 sets when the regulator output loses regulation.
// - Raw bit 1 records brown-out; interrupts only if enabled and select clear.
// - Raw bit 0 sets when the PLL stops oscillating.
// - Mask bits 6 to 0 pass matching raw bits to the interrupt; bit 1 passes only while the brown-out select is clear.
// - Mask bits reset to zero so nothing interrupts until enabled.
// - Masked status reads raw AND mask; writing one clears the raw bit, not the mask.
// - Brown-out select set gives a system reset, clear gives an interrupt.
`timescale 1ns/1ps
module ssri_top
    import ssri_pkg::*;
#(
    parameter int                ADDR_W     = 8,
    parameter logic [31:0]       PERIPH_CAP = 32'h0303_0011,
    parameter logic [GPIO_W-1:0] GPIO_CAP   = 3'h7
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    input  wire logic              i_pll_lock,
    input  wire logic              i_current_limit,
    input  wire logic              i_boot_osc_fault,
    input  wire logic              i_main_osc_fault,
    input  wire logic              i_regulator_loss,
    input  wire logic              i_brownout,
    input  wire logic              i_pll_fault,
    output logic [31:0]            o_periph_reset,
    output logic [GPIO_W-1:0]      o_gpio_reset,
    output logic                   o_brownout_sys_reset,
    output logic                   o_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [31:0]       periph_rst;
        logic [GPIO_W-1:0] gpio_rst;
        logic [EVT_W-1:0]  mask;
        logic [BOR_W-1:0]  bor_ctl;
    } ssri_state_t;

    ssri_state_t s;
    ssri_state_t next_s;

    ssri_evt_if evt ();

    logic [EVT_W-1:0] enabled;
    logic             commit;
    logic             bor_sel;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] low_ofs(input logic [ADDR_W-1:0] a);
        return {a[7:2], 2'b00};
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = low_ofs(a);
        return ((a >> 8) == '0) &&
               (o == OFS_PERIPH_CAP || o == OFS_GPIO_CAP ||
                o == OFS_BOR_CTL    || o == OFS_PERIPH_RST ||
                o == OFS_GPIO_RST   || o == OFS_RAW ||
                o == OFS_MASK       || o == OFS_MASKED);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    ssri_evt_capture u_cap (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_events ({i_pll_lock, i_current_limit, i_boot_osc_fault,
                    i_main_osc_fault, i_regulator_loss, i_brownout,
                    i_pll_fault}),
        .evt      (evt.capture)
    );

    // ------------------------------------------------------------
    // Interrupt and brown-out routing
    // ------------------------------------------------------------
    assign bor_sel = s.bor_ctl[BIT_BOR_SELECT];

    // The brown-out term is dropped while the select routes it to reset.
    always_comb
    begin
        enabled = evt.raw & s.mask;
        enabled[BIT_BROWNOUT] = evt.raw[BIT_BROWNOUT] & s.mask[BIT_BROWNOUT]
                                & ~bor_sel;
    end

    assign o_irq = |enabled;

    // The raw bit already carries two synchroniser stages, so the reset
    // request follows the pin by three cycles.
    assign o_brownout_sys_reset = evt.raw[BIT_BROWNOUT] & bor_sel;

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign o_awready = ~s.aw_got & ~s.bvalid;
    assign o_wready  = ~s.w_got & ~s.bvalid;
    assign o_arready = ~s.rvalid;
    assign commit    = s.aw_got & s.w_got;

    always_comb
    begin
        evt.clear = '0;
        if (commit && low_ofs(s.awaddr) == OFS_MASKED && (s.awaddr >> 8) == '0
            && s.wstrb[0])
        begin
            evt.clear = s.wdata[EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb
    begin
        logic [31:0] m;
        m      = '0;
        next_s = s;
        if (i_awvalid && o_awready)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = i_wdata;
            next_s.wstrb = i_wstrb;
        end
        if (commit)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = is_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if ((s.awaddr >> 8) == '0)
            begin
                unique case (low_ofs(s.awaddr))
                    OFS_PERIPH_RST:
                    begin
                        m = merge(s.periph_rst, s.wdata, s.wstrb);
                        next_s.periph_rst = m & PERIPH_CAP & PERIPH_IMPL;
                    end
                    OFS_GPIO_RST:
                    begin
                        m = merge({29'h0, s.gpio_rst}, s.wdata, s.wstrb);
                        next_s.gpio_rst = m[GPIO_W-1:0] & GPIO_CAP;
                    end
                    OFS_MASK:
                    begin
                        m = merge({25'h0, s.mask}, s.wdata, s.wstrb);
                        next_s.mask = m[EVT_W-1:0];
                    end
                    OFS_BOR_CTL:
                    begin
                        m = merge({16'h0, s.bor_ctl}, s.wdata, s.wstrb);
                        next_s.bor_ctl = m[BOR_W-1:0];
                    end
                    default:
                    begin
                        m = '0;
                    end
                endcase
            end
        end
        if (s.bvalid && i_bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            next_s.rdata  = '0;
            if ((i_araddr >> 8) == '0)
            begin
                unique case (low_ofs(i_araddr))
                    OFS_PERIPH_CAP: next_s.rdata = PERIPH_CAP;
                    OFS_GPIO_CAP:   next_s.rdata = {29'h0, GPIO_CAP};
                    OFS_BOR_CTL:    next_s.rdata = {16'h0, s.bor_ctl};
                    OFS_PERIPH_RST: next_s.rdata = s.periph_rst;
                    OFS_GPIO_RST:   next_s.rdata = {29'h0, s.gpio_rst};
                    OFS_RAW:        next_s.rdata = {25'h0, evt.raw};
                    OFS_MASK:       next_s.rdata = {25'h0, s.mask};
                    OFS_MASKED:     next_s.rdata = {25'h0, evt.raw & s.mask};
                    default:        next_s.rdata = '0;
                endcase
            end
        end
        else if (s.rvalid && i_rready)
        begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s            <= '0;
            s.periph_rst <= PERIPH_RST_VAL;
            s.gpio_rst   <= GPIO_RST_VAL;
            s.mask       <= MASK_RST_VAL;
            s.bor_ctl    <= BOR_CTL_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_bvalid       = s.bvalid;
    assign o_bresp        = s.bresp;
    assign o_rvalid       = s.rvalid;
    assign o_rdata        = s.rdata;
    assign o_rresp        = s.rresp;
    assign o_periph_reset = s.periph_rst;
    assign o_gpio_reset   = s.gpio_rst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_periph_cap_gate: assert property (
        (s.periph_rst & ~PERIPH_CAP) == '0)
        else $error("peripheral reset bit set outside capability");
    chk_gpio_cap_gate: assert property (
        (s.gpio_rst & ~GPIO_CAP) == '0)
        else $error("gpio reset bit set outside capability");
    chk_periph_write: assert property (
        commit && s.awaddr == ADDR_W'(OFS_PERIPH_RST) && s.wstrb == 4'hF
        |=> o_periph_reset == ($past(s.wdata) & PERIPH_CAP & PERIPH_IMPL)
            && o_bvalid)
        else $error("peripheral reset write not applied");
    chk_gpio_write: assert property (
        commit && s.awaddr == ADDR_W'(OFS_GPIO_RST) && s.wstrb[0]
        |=> o_gpio_reset == ($past(s.wdata[GPIO_W-1:0]) & GPIO_CAP))
        else $error("gpio reset write not applied");
    chk_mask_after_reset: assert property (
        $past(i_rst) |-> s.mask == '0 && !o_irq)
        else $error("mask not clear after reset");
    chk_irq_follows: assert property (
        (evt.raw[BIT_PLL_LOCK] && s.mask[BIT_PLL_LOCK] |-> o_irq) and
        ((evt.raw & s.mask) == '0 |-> !o_irq))
        else $error("interrupt does not follow enabled status");
    chk_bor_select: assert property (
        evt.raw[BIT_BROWNOUT] && bor_sel
        |-> o_brownout_sys_reset && (enabled[BIT_BROWNOUT] == 1'b0))
        else $error("brown-out routed wrongly");
    chk_w1c_clear: assert property (
        commit && s.awaddr == ADDR_W'(OFS_MASKED) && s.wstrb[0]
        && s.wdata[BIT_PLL_FAULT] && !i_pll_fault && !$past(i_pll_fault, 2)
        |=> !evt.raw[BIT_PLL_FAULT])
        else $error("masked status write did not clear raw bit");
    chk_unmapped_resp: assert property (
        i_arvalid && o_arready && !is_mapped(i_araddr)
        |=> o_rvalid && o_rresp == RESP_SLVERR && o_rdata == '0)
        else $error("unmapped read not refused");

    cov_irq_raised: cover property (!o_irq ##1 o_irq);
    cov_bor_reset: cover property ($rose(o_brownout_sys_reset));
    cov_periph_hold: cover property (o_periph_reset[BIT_FIRST_UART] [*3]);
    cov_back_to_back: cover property (o_bvalid && i_bready ##1 commit);

endmodule

// [rtl/ssri_pkg.sv]
/*
 * Shared constants for the system control soft reset and interrupt block.
 * Assumes a 32-bit AXI4-Lite register bus and seven event sources.
 */
package ssri_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PERIPH_CAP = 8'h14;
    localparam logic [7:0] OFS_GPIO_CAP   = 8'h1C;
    localparam logic [7:0] OFS_BOR_CTL    = 8'h30;
    localparam logic [7:0] OFS_PERIPH_RST = 8'h44;
    localparam logic [7:0] OFS_GPIO_RST   = 8'h48;
    localparam logic [7:0] OFS_RAW        = 8'h50;
    localparam logic [7:0] OFS_MASK       = 8'h54;
    localparam logic [7:0] OFS_MASKED     = 8'h58;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int EVT_W          = 7;
    localparam int GPIO_W         = 3;
    localparam int BOR_W          = 16;
    localparam int BIT_CMP_ONE    = 25;
    localparam int BIT_CMP_ZERO   = 24;
    localparam int BIT_TIMER1     = 17;
    localparam int BIT_TIMER0     = 16;
    localparam int BIT_SYNC_SER   = 4;
    localparam int BIT_FIRST_UART = 0;
    localparam int BIT_PLL_LOCK   = 6;
    localparam int BIT_CUR_LIMIT  = 5;
    localparam int BIT_BOOT_OSC   = 4;
    localparam int BIT_MAIN_OSC   = 3;
    localparam int BIT_REG_LOSS   = 2;
    localparam int BIT_BROWNOUT   = 1;
    localparam int BIT_PLL_FAULT  = 0;
    localparam int BIT_BOR_SELECT = 1;

    // Implemented bits of the peripheral reset register.
    localparam logic [31:0] PERIPH_IMPL = 32'h0303_0011;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0]       PERIPH_RST_VAL = 32'h0000_0000;
    localparam logic [GPIO_W-1:0] GPIO_RST_VAL   = 3'h0;
    localparam logic [EVT_W-1:0]  MASK_RST_VAL   = 7'h00;
    localparam logic [EVT_W-1:0]  RAW_RST_VAL    = 7'h00;
    localparam logic [BOR_W-1:0]  BOR_CTL_RST    = 16'h7FFD;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/ssri_evt_if.sv]
/*
 * Carrier between the register front end and the event capture logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ssri_evt_if
    import ssri_pkg::*;
();
    logic [EVT_W-1:0] raw;
    logic [EVT_W-1:0] clear;

    modport capture (input clear, output raw);
    modport control (input raw, output clear);
endinterface

// [rtl/ssri_evt_capture.sv]
/*
 * Raw event status: synchronises event pins and keeps sticky raw bits.
 * Assumes event pins are asynchronous and the clear vector is one cycle.
 */
`timescale 1ns/1ps
module ssri_evt_capture
    import ssri_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [EVT_W-1:0] i_events,
    ssri_evt_if.capture           evt
);

    typedef struct packed {
        logic [EVT_W-1:0] sync1;
        logic [EVT_W-1:0] sync2;
        logic [EVT_W-1:0] prev;
        logic [EVT_W-1:0] raw;
    } ssri_cap_t;

    ssri_cap_t s;
    ssri_cap_t next_s;

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    // A rising edge sets the bit; a level would re-set it at once after
    // a clear and make the clear useless while the source stays high.
    always_comb
    begin
        next_s       = s;
        next_s.sync1 = i_events;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;
        next_s.raw   = (s.raw & ~evt.clear) | (s.sync2 & ~s.prev);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s <= '{RAW_RST_VAL, RAW_RST_VAL, RAW_RST_VAL, RAW_RST_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign evt.raw = s.raw;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_edge_sets_raw: assert property (
        1'b1 |=> &(s.raw | ~$past(s.sync2 & ~s.prev)))
        else $error("event edge did not set its raw bit");
    chk_raw_fall_cause: assert property (
        1'b1 |=> ($past(s.raw) & ~s.raw & ~$past(evt.clear)) == '0)
        else $error("raw bit fell without a clear");
    chk_raw_reset_zero: assert property (
        $past(i_rst) |-> s.raw == RAW_RST_VAL)
        else $error("raw status not zero after reset");

    cov_clear_vs_set: cover property (evt.clear[BIT_BROWNOUT] && s.sync2[BIT_BROWNOUT]
                                      && !s.prev[BIT_BROWNOUT]);

endmodule

// [sim/ssri_core_model.sv]
/*
 * Core-side model: an AXI4-Lite master that software tasks use to reach registers.
 * Assumes it shares the block's clock and its tasks are entered just after a rising edge.
 */
`timescale 1ns/1ps
module ssri_core_model
(
    input  wire logic        i_clk,
    output logic [7:0]       o_awaddr,
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    input  wire logic [1:0]  i_bresp,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    output logic [7:0]       o_araddr,
    output logic             o_arvalid,
    input  wire logic        i_arready,
    input  wire logic [31:0] i_rdata,
    input  wire logic [1:0]  i_rresp,
    input  wire logic        i_rvalid,
    output logic             o_rready
);
    // Response readies stay high, so a response is taken at the first edge it shows.
    initial
    begin
        {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid} = '0;
        {o_araddr, o_arvalid} = '0;
        o_bready = 1'b1;
        o_rready = 1'b1;
    end

    // Callers hand over reserved bits as they read back: zero, or ones in BOR control.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                      input logic [3:0] st = 4'hF);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        o_awaddr  <= a;
        o_awvalid <= 1'b1;
        o_wdata   <= d;
        o_wstrb   <= st;
        o_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_clk);
            if (!aw_ok && i_awready)
            begin
                aw_ok = 1'b1;
                o_awvalid <= 1'b0;
            end
            if (!w_ok && i_wready)
            begin
                w_ok = 1'b1;
                o_wvalid <= 1'b0;
            end
        end
        while (!i_bvalid) @(posedge i_clk);
        r = i_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        o_araddr  <= a;
        o_arvalid <= 1'b1;
        @(posedge i_clk);
        while (!i_arready) @(posedge i_clk);
        o_arvalid <= 1'b0;
        while (!i_rvalid) @(posedge i_clk);
        d = i_rdata;
        r = i_rresp;
    endtask
endmodule

// [sim/ssri_top_tb.sv]
/*
 * Self-checking bench for the soft reset and interrupt block.
 * Assumes the core model drives the register bus and the bench drives the event pins.
 */
`timescale 1ns/1ps
module ssri_top_tb
    import ssri_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    // Timer 1 and port B are absent so the write gating has bits to remove.
    localparam logic [31:0]       P_CAP = 32'h0301_0011;
    localparam logic [GPIO_W-1:0] G_CAP = 3'h5;
    logic              clk;
    logic              rst;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, prst;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, bor_rst, irq;
    logic [EVT_W-1:0]  ev;
    logic [GPIO_W-1:0] grst;
    int                err_count;
    int                checks_done;
    int                cycles;

    ssri_top #(.ADDR_W(8), .PERIPH_CAP(P_CAP), .GPIO_CAP(G_CAP)) i_ssri_top
    (
        .i_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .i_pll_lock(ev[BIT_PLL_LOCK]),
        .i_current_limit(ev[BIT_CUR_LIMIT]), .i_boot_osc_fault(ev[BIT_BOOT_OSC]),
        .i_main_osc_fault(ev[BIT_MAIN_OSC]), .i_regulator_loss(ev[BIT_REG_LOSS]),
        .i_brownout(ev[BIT_BROWNOUT]), .i_pll_fault(ev[BIT_PLL_FAULT]),
        .o_periph_reset(prst), .o_gpio_reset(grst), .o_brownout_sys_reset(bor_rst), .o_irq(irq)
    );

    ssri_core_model i_ssri_core_model
    (
        .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
        .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
        .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
        .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
        .i_rvalid(rvalid), .o_rready(rready)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        i_ssri_core_model.wr(a, d, r);
        chk($sformatf("bresp %h", a), {30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        i_ssri_core_model.rd(a, d, r);
        chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, RESP_OKAY});
        chk($sformatf("rdata %h", a), d, exp);
    endtask

    // The pin is held long enough to pass the two-stage synchroniser.
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        repeat (2) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        rchk(OFS_PERIPH_RST, 32'h0);
        rchk(OFS_GPIO_RST, 32'h0);
        rchk(OFS_RAW, 32'h0);
        rchk(OFS_MASK, 32'h0);
        rchk(OFS_PERIPH_CAP, P_CAP);
        rchk(OFS_GPIO_CAP, {29'h0, G_CAP});
        rchk(OFS_BOR_CTL, {16'h0, BOR_CTL_RST});
        chk("irq", {31'h0, irq}, 32'h0);
        chk("periph out", prst, 32'h0);
        i_ssri_core_model.rd(8'h60, d, r);
        chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        chk("unmapped rdata", d, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_soft;
        logic [1:0] r;
        w(OFS_PERIPH_RST, 32'h0303_0011);
        rchk(OFS_PERIPH_RST, P_CAP);
        chk("periph out", prst, P_CAP);
        w(OFS_PERIPH_RST, 32'h0);
        rchk(OFS_PERIPH_RST, 32'h0);
        chk("periph out", prst, 32'h0);
        i_ssri_core_model.wr(OFS_PERIPH_RST, 32'h0303_0011, r, 4'h8);
        rchk(OFS_PERIPH_RST, 32'h0300_0000);
        w(OFS_GPIO_RST, 32'h7);
        rchk(OFS_GPIO_RST, 32'h5);
        chk("gpio out", {29'h0, grst}, 32'h5);
        w(OFS_GPIO_RST, 32'h0);
        i_ssri_core_model.wr(8'h60, 32'h1, r);
        chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        $display("t_soft done");
    endtask

    task automatic t_events;
        logic [31:0] exp;
        exp = 32'h0;
        for (int i = 0; i < EVT_W; i++)
        begin
            pulse(i);
            exp[i] = 1'b1;
            rchk(OFS_RAW, exp);
        end
        chk("irq", {31'h0, irq}, 32'h0);
        w(OFS_RAW, 32'h0);
        rchk(OFS_RAW, 32'h7F);
        $display("t_events done");
    endtask

    task automatic t_mask;
        logic [31:0] exp;
        for (int i = 0; i < EVT_W; i++)
        begin
            w(OFS_MASK, 32'h1 << i);
            rchk(OFS_MASK, 32'h1 << i);
            chk("irq", {31'h0, irq}, 32'h1);
        end
        w(OFS_MASK, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        w(OFS_MASK, 32'h55);
        rchk(OFS_MASKED, 32'h55);
        w(OFS_MASK, 32'h7F);
        exp = 32'h7F;
        for (int i = 0; i < EVT_W; i++)
        begin
            w(OFS_MASKED, 32'h1 << i);
            exp[i] = 1'b0;
            rchk(OFS_RAW, exp);
            chk("irq", {31'h0, irq}, {31'h0, exp != 0});
        end
        $display("t_mask done");
    endtask

    task automatic t_brownout;
        w(OFS_MASK, 32'h2);
        pulse(BIT_BROWNOUT);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("bor reset", {31'h0, bor_rst}, 32'h0);
        w(OFS_BOR_CTL, 32'h7FFF);
        chk("irq", {31'h0, irq}, 32'h0);
        chk("bor reset", {31'h0, bor_rst}, 32'h1);
        w(OFS_BOR_CTL, 32'h7FFD);
        chk("irq", {31'h0, irq}, 32'h1);
        w(OFS_MASKED, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("t_brownout done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles; the ceiling leaves wide margin.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            complete_run();
        end
    end

    initial
    begin
        rst = 1'b1;
        ev = '0;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_soft();
        t_events();
        t_mask();
        t_brownout();
        complete_run();
    end
endmodule
